// ==== rtl/rewind_pkg.sv ====
// constants, state codes and timing for the rewind sequencer
// assumes a single 10 MHz logic clock for every counted delay
package rewind_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int IDLE_TIME_MS = 12;
  localparam int IDLE_CYCLES = (IDLE_TIME_MS * (CLK_HZ / 1000));
  localparam int RESET_HOLD_MS = 500;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 24;
  localparam logic [3:0] KICK_QTR_COUNTS = 4'h8;
  localparam logic [3:0] REF_LAST = 4'hf;
  localparam logic [3:0] REEL_FAST_MIN = 4'h2;
  localparam logic [3:0] REEL_CNT_MAX = 4'hf;
  localparam int PHR_W = 4;
  localparam logic [PHR_W-1:0] PHR_NORMAL = 4'hf;
  localparam logic [PHR_W-1:0] PHR_CLEAR = 4'h0;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_KICK = 6'h02,
    ST_BACK = 6'h04,
    ST_HIGH = 6'h08,
    ST_SLOW = 6'h10,
    ST_LOW = 6'h20
  } state_e;
endpackage

// ==== rtl/rewind_if.sv ====
// signals shared between the sequencer and its two helpers
// assumes the sequencer drives the tach and motion inputs
`timescale 1ns/1ps
`default_nettype none
interface rewind_if;
  logic capstan_tach;
  logic left_reel_tach;
  logic right_reel_tach;
  logic ref_pulse;
  logic [1:0] reel_fast;
  logic motion_request_extended;
  logic idle_long;
  modport cmp(input capstan_tach, input left_reel_tach,
    input right_reel_tach, output ref_pulse, output reel_fast);
  modport tmr(input motion_request_extended, output idle_long);
endinterface
`default_nettype wire

// ==== rtl/reel_speed_compare.sv ====
// reference pulse generator and reel against capstan speed comparison
// assumes one-cycle tach pulses synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module reel_speed_compare (
  input wire logic clk,
  input wire logic arst_n,
  rewind_if.cmp link
);
  import rewind_pkg::*;
  typedef struct packed {
    logic [3:0] cap;
    logic [1:0][3:0] reel;
    logic [1:0] fast;
    logic ref_p;
  } cmp_s;
  cmp_s r;
  cmp_s n;
  logic [1:0] tach;

  assign tach = {link.right_reel_tach, link.left_reel_tach};

  always_comb begin
    n = r;
    n.ref_p = 1'b0;
    if (link.capstan_tach) begin
      // one reference pulse per group of capstan pulses [RL17]
      if (r.cap == REF_LAST) begin
        n.cap = 4'h0;
        n.ref_p = 1'b1;
      end else begin
        n.cap = r.cap + 4'h1;
      end
    end
    // a reel pulse landing on the window edge is dropped; harmless jitter
    for (int i = 0; i < 2; i++) begin
      if (n.ref_p) begin
        n.fast[i] = (r.reel[i] >= REEL_FAST_MIN); // [RL17]
        n.reel[i] = 4'h0;
      end else if (tach[i] && r.reel[i] != REEL_CNT_MAX) begin
        n.reel[i] = r.reel[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign link.ref_pulse = r.ref_p;
  assign link.reel_fast = r.fast;

  a_ref_group: assert property (@(posedge clk) disable iff (!arst_n)
    r.ref_p |-> $past(r.cap) == REF_LAST) // [RL17]
    else $error("reference pulse off its capstan count");
endmodule
`default_nettype wire

// ==== rtl/idle_timer.sv ====
// measures how long the motion request has been down
// assumes motion_request_extended is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module idle_timer #(
  parameter int IDLE_CYCLES = rewind_pkg::IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  rewind_if.tmr link
);
  import rewind_pkg::*;
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic idle;
  } tmr_s;
  tmr_s r;
  tmr_s n;
  localparam logic [TMR_W-1:0] LIMIT = TMR_W'(IDLE_CYCLES);

  always_comb begin
    n = r;
    if (link.motion_request_extended) begin
      n.cnt = '0;
    end else if (r.cnt != LIMIT) begin
      n.cnt = r.cnt + 1'b1;
    end
    n.idle = (n.cnt == LIMIT); // [RL5]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign link.idle_long = r.idle;
endmodule
`default_nettype wire

// ==== rtl/tape_rewind_sequencer.sv ====
// rewind sequencer: start, forward kick, reel feed, high/low speed, stop
// assumes all inputs synchronous to clk and tach inputs one cycle wide
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: beginning-of-tape marker ends the rewind and stops tape motion; code acts on load_point only in ST_BACK and ST_LOW.
// RL2: little tape on left reel at start means whole rewind at low speed.
// RL3: after high speed ends, rewind continues at low speed to load point.
// RL4: start on rewind command, or either rewind button when not ready.
// RL5: tape idle past threshold at start means begin with forward motion.
// RL6: forward kick lasts eight quarter tach counts, then go backward.
// RL7: left reel turns ccw while left loop is above left middle port.
// RL8: right reel turns ccw while right loop is below right middle port.
// RL9: high-speed field latch sets only after both reels beat capstan.
// RL10: high-speed field latch holds the polarity hold register reset.
// RL11: with polarity hold reset, capstan runs from rewind/slowdown currents.
// RL12: at high speed the currents follow the reel/capstan comparison.
// RL13: left radius sense asserts slowdown and ends high speed.
// RL14: slowdown tracks first slowing reel until capstan below normal.
// RL15: a reset press during high speed also asserts slowdown.
// RL16: reset held or pressed again during rewind stops the tape.
// RL17: reference pulse every sixteen capstan tach pulses, reels compared.
// RL18: conflicting column demands: coast wins over drive.
// RL19: system reset abandons rewind, clears latch, returns to idle.
module tape_rewind_sequencer #(
  parameter int IDLE_CYCLES = rewind_pkg::IDLE_CYCLES,
  parameter int RESET_HOLD_CYCLES = rewind_pkg::RESET_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rewind_cmd,
  input wire logic unload_rewind_btn,
  input wire logic load_rewind_btn,
  input wire logic unit_ready,
  input wire logic reset_btn,
  input wire logic load_point,
  input wire logic left_radius_sense,
  input wire logic motion_request_extended,
  input wire logic capstan_tach,
  input wire logic capstan_quarter_tach,
  input wire logic left_reel_tach,
  input wire logic right_reel_tach,
  input wire logic left_column_mid_port,
  input wire logic right_column_mid_port,
  input wire logic capstan_below_normal,
  output logic rewind_active,
  output logic tape_fwd,
  output logic tape_bkwd,
  output logic capstan_normal_ctl,
  output logic rewind_current,
  output logic slowdown_current,
  output logic slowdown,
  output logic high_speed_field,
  output logic [rewind_pkg::PHR_W-1:0] polarity_hold_register,
  output logic left_reel_ccw,
  output logic right_reel_ccw,
  output logic rewind_done
);
  import rewind_pkg::*;

  typedef struct packed {
    state_e st;
    logic [3:0] kick;
    logic low_only;
    logic hsf;
    logic [PHR_W-1:0] phr;
    logic rst_prev;
    logic rst_seen;
    logic [TMR_W-1:0] hold;
    logic done;
    logic fwd;
    logic bkwd;
    logic rw_cur;
    logic sd_cur;
    logic step_down;
  } seq_s;

  localparam logic [TMR_W-1:0] HOLD_LIMIT = TMR_W'(RESET_HOLD_CYCLES);

  seq_s r;
  seq_s n;
  rewind_if link ();
  logic start;
  logic rst_edge;
  logic active;
  logic both_fast;
  logic abort;

  assign link.capstan_tach = capstan_tach;
  assign link.left_reel_tach = left_reel_tach;
  assign link.right_reel_tach = right_reel_tach;
  assign link.motion_request_extended = motion_request_extended;

  reel_speed_compare u_cmp (
    .clk(clk),
    .arst_n(arst_n),
    .link(link)
  );

  idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_tmr (
    .clk(clk),
    .arst_n(arst_n),
    .link(link)
  );

  // buttons only count while the unit is not ready [RL4]
  assign start = rewind_cmd |
    ((unload_rewind_btn | load_rewind_btn) & ~unit_ready);
  assign rst_edge = reset_btn & ~r.rst_prev;
  assign active = (r.st != ST_IDLE);
  // each column circuit drives only when its reel is fast; any coast
  // demand overrides, so drive needs both [RL18]
  assign both_fast = &link.reel_fast;
  // second press or a long hold stops the tape [RL16]
  assign abort = active &&
    ((rst_edge && r.rst_seen) || (reset_btn && r.hold == HOLD_LIMIT));

  always_comb begin
    n = r;
    n.rst_prev = reset_btn;
    n.done = 1'b0;
    if (active && reset_btn && r.hold != HOLD_LIMIT) begin
      n.hold = r.hold + 1'b1;
    end else if (!reset_btn) begin
      n.hold = '0;
    end
    if (active && rst_edge) begin
      n.rst_seen = 1'b1;
    end
    case (r.st)
      ST_IDLE: begin
        if (start) begin
          // sampled once: a nearly empty left reel never goes fast [RL2]
          n.low_only = left_radius_sense;
          n.kick = 4'h0;
          n.rst_seen = 1'b0;
          n.hold = '0;
          n.step_down = 1'b0;
          n.st = link.idle_long ? ST_KICK : ST_BACK; // [RL5]
        end
      end
      ST_KICK: begin
        if (capstan_quarter_tach) begin
          n.kick = r.kick + 4'h1; // [RL6]
          if (r.kick == KICK_QTR_COUNTS - 4'h1) begin
            n.st = ST_BACK;
          end
        end
      end
      ST_BACK: begin
        if (load_point) begin
          n.st = ST_IDLE; // [RL1]
          n.done = 1'b1;
        end else if (!r.low_only && both_fast) begin
          n.hsf = 1'b1; // [RL9]
          n.st = ST_HIGH;
        end
      end
      ST_HIGH: begin
        // radius sense or a first reset press starts slowdown
        if (left_radius_sense || (rst_edge && !r.rst_seen)) begin
          n.step_down = 1'b1; // [RL13] [RL15]
          n.st = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (capstan_below_normal) begin
          n.hsf = 1'b0; // [RL14]
          n.st = ST_LOW; // [RL3]
        end
      end
      ST_LOW: begin
        if (load_point) begin
          n.st = ST_IDLE; // [RL1]
          n.done = 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (abort) begin
      n.st = ST_IDLE;
      n.done = 1'b0;
    end
    if (n.st == ST_IDLE) begin
      n.hsf = 1'b0;
      n.step_down = 1'b0;
    end
    n.fwd = (n.st == ST_KICK);
    n.bkwd = (n.st != ST_IDLE) && (n.st != ST_KICK);
    // latch forces the polarity hold register clear [RL10]
    if (n.hsf || n.st == ST_IDLE) begin
      n.phr = PHR_CLEAR;
    end else begin
      n.phr = PHR_NORMAL;
    end
    // currents only act with the polarity hold register clear [RL11]
    if (n.phr == PHR_CLEAR && (n.st == ST_HIGH || n.st == ST_SLOW)) begin
      // comparison steers drive or coast; coast wins [RL12] [RL14] [RL18]
      n.rw_cur = both_fast;
      n.sd_cur = ~both_fast;
    end else begin
      n.rw_cur = 1'b0;
      n.sd_cur = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: ST_IDLE, default: '0}; // [RL19]
    end else begin
      r <= n;
    end
  end

  assign rewind_active = active;
  assign tape_fwd = r.fwd;
  assign tape_bkwd = r.bkwd;
  assign capstan_normal_ctl = active && (r.phr != PHR_CLEAR); // [RL11]
  assign rewind_current = r.rw_cur;
  assign slowdown_current = r.sd_cur;
  assign slowdown = r.step_down;
  assign high_speed_field = r.hsf;
  assign polarity_hold_register = r.phr;
  // reel feed follows the column ports only while rewinding
  assign left_reel_ccw = active && left_column_mid_port; // [RL7]
  assign right_reel_ccw = active && right_column_mid_port; // [RL8]
  assign rewind_done = r.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_idle_start;
    r.st == ST_IDLE && start;
  endsequence

  sequence s_kick_run;
    r.st == ST_KICK [*1] ##1 r.fwd;
  endsequence

  sequence s_fast_mixed;
    r.st == ST_HIGH && !both_fast;
  endsequence

  sequence s_still_high;
    r.st == ST_HIGH;
  endsequence

  a_bot_ends: assert property ((r.st == ST_BACK || r.st == ST_LOW) &&
    load_point && !abort |=> r.st == ST_IDLE && rewind_done) // [RL1]
    else $error("load point did not end the rewind");
  a_low_only_slow: assert property (r.low_only && active |-> !r.hsf) // [RL2]
    else $error("high speed entered on a short reel");
  a_slow_to_low: assert property (r.st == ST_SLOW && capstan_below_normal
    && !abort |=> r.st == ST_LOW && !r.hsf) // [RL3]
    else $error("slowdown did not hand over to low speed");
  a_cmd_starts: assert property (s_idle_start |=> active) // [RL4]
    else $error("rewind request ignored");
  a_kick_first: assert property (s_idle_start ##0 link.idle_long
    |=> s_kick_run) // [RL5]
    else $error("idle tape did not start forward");
  a_kick_len: assert property ($rose(r.st == ST_BACK) && $past(r.fwd)
    |-> $past(r.kick) == KICK_QTR_COUNTS - 4'h1) // [RL6]
    else $error("forward kick length wrong");
  a_hsf_cause: assert property ($rose(r.hsf) |-> $past(both_fast)
    && !r.low_only) // [RL9]
    else $error("field latch set without fast reels");
  a_phr_held: assert property (r.hsf |-> r.phr == PHR_CLEAR
    && !capstan_normal_ctl) // [RL10]
    else $error("polarity hold register not clear at high speed");
  a_hs_current: assert property (r.st == ST_HIGH && r.hsf ##1
    r.st == ST_HIGH |-> rewind_current == $past(both_fast)
    && slowdown_current != rewind_current) // [RL12]
    else $error("currents do not follow the comparison");
  a_rst_slowdown: assert property (r.st == ST_HIGH && rst_edge &&
    !r.rst_seen && !abort |=> slowdown && r.st == ST_SLOW) // [RL15]
    else $error("reset press did not slow down");
  a_second_stop: assert property (active && rst_edge && r.rst_seen
    |=> r.st == ST_IDLE && !tape_bkwd && !tape_fwd) // [RL16]
    else $error("second reset press did not stop tape");
  // reel feed must stay off in idle, where the loops are not watched
  a_reel_feed: assert property ((left_reel_ccw == (active &&
    left_column_mid_port)) && (right_reel_ccw == (active &&
    right_column_mid_port))) // [RL7] [RL8]
    else $error("reel feed does not follow the column ports");
  a_radius_slow: assert property (r.st == ST_HIGH && left_radius_sense &&
    !abort |=> slowdown && r.st == ST_SLOW) // [RL13]
    else $error("radius sense did not start slowdown");
  a_slow_track: assert property (r.st == ST_SLOW |-> rewind_current ==
    $past(both_fast) && slowdown_current == !rewind_current) // [RL14]
    else $error("slowdown currents do not track the reels");
  // the edge that leaves high speed is not covered by this check
  a_coast_wins: assert property (s_fast_mixed ##1 s_still_high |->
    slowdown_current && !rewind_current) // [RL18]
    else $error("drive won over a coast demand");
  a_hold_stop: assert property (active && reset_btn && r.hold == HOLD_LIMIT
    |=> r.st == ST_IDLE && !tape_fwd && !tape_bkwd) // [RL16]
    else $error("held reset did not stop tape");
  a_idle_quiet: assert property (r.st == ST_IDLE |-> !r.hsf && !slowdown
    && r.phr == PHR_CLEAR) // [RL19]
    else $error("idle state left latch or slowdown set");
endmodule
`default_nettype wire

// ==== verification/tape_control_model.sv ====
// partner model: the tape control that issues rewind commands
// assumes the bench asks for a command through send
`timescale 1ns/1ps
`default_nettype none
module tape_control_model (
  input wire logic clk,
  input wire logic send,
  output logic rewind_cmd
);
  logic req;
  initial req = 1'b0;
  initial rewind_cmd = 1'b0;
  // latched on the rising edge, launched on the falling one, so the
  // sequencer never samples a command that moves in its own time step
  always @(posedge clk) begin
    req <= send;
  end
  always @(negedge clk) begin
    rewind_cmd <= req;
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the rewind sequencer
// assumes a 10 MHz clock and shortened idle and reset-hold counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
`define WAITFOR(c) begin for (k = 0; k < 60 && !(c); k++) @(negedge clk); \
  if (k == 60) begin num_errors++; close_out(); end end
module testbench;
  import rewind_pkg::*;
  localparam int IDLE_N = 20;
  localparam int HOLD_N = 30;
  logic clk, arst_n, send, rewind_cmd, unload_rewind_btn, load_rewind_btn;
  logic unit_ready, reset_btn, load_point, left_radius_sense;
  logic motion_request_extended, capstan_tach, capstan_quarter_tach;
  logic left_reel_tach, right_reel_tach, left_column_mid_port;
  logic right_column_mid_port, capstan_below_normal;
  logic rewind_active, tape_fwd, tape_bkwd, capstan_normal_ctl;
  logic rewind_current, slowdown_current, slowdown, high_speed_field;
  logic left_reel_ccw, right_reel_ccw, rewind_done;
  logic [PHR_W-1:0] polarity_hold_register;
  int num_errors = 0;
  int tests_run = 0;
  int k;
  typedef struct packed {logic c, u, l, r, a;} row_s;
  // command, unload button, load button, ready, expected start
  row_s rows [6] = '{5'b10001, 5'b01001, 5'b00101, 5'b01010, 5'b00110,
    5'b10011};

  tape_control_model u_tcu (.clk, .send, .rewind_cmd);
  tape_rewind_sequencer #(.IDLE_CYCLES(IDLE_N), .RESET_HOLD_CYCLES(HOLD_N))
    u_dut (.clk, .arst_n, .rewind_cmd, .unload_rewind_btn, .load_rewind_btn,
    .unit_ready, .reset_btn, .load_point, .left_radius_sense,
    .motion_request_extended, .capstan_tach, .capstan_quarter_tach,
    .left_reel_tach, .right_reel_tach, .left_column_mid_port,
    .right_column_mid_port, .capstan_below_normal, .rewind_active,
    .tape_fwd, .tape_bkwd, .capstan_normal_ctl, .rewind_current,
    .slowdown_current, .slowdown, .high_speed_field,
    .polarity_hold_register, .left_reel_ccw, .right_reel_ccw, .rewind_done);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one reference window; reel pulses kept off the window edges
  task automatic win(input int nl, input int nr);
    for (int i = 0; i < 16; i++) begin
      capstan_tach = 1'b1;
      tick(1);
      capstan_tach = 1'b0;
      left_reel_tach = (i > 1 && i < nl + 2);
      right_reel_tach = (i > 1 && i < nr + 2);
      tick(1);
      left_reel_tach = 1'b0;
      right_reel_tach = 1'b0;
    end
  endtask

  task automatic start_cmd();
    send = 1'b1;
    tick(1);
    send = 1'b0;
    tick(2);
  endtask

  task automatic press(input int n);
    reset_btn = 1'b1;
    tick(n);
    reset_btn = 1'b0;
    tick(1);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    {arst_n, send, unload_rewind_btn, load_rewind_btn, unit_ready} = '0;
    {reset_btn, load_point, left_radius_sense, capstan_tach} = '0;
    {capstan_quarter_tach, left_reel_tach, right_reel_tach} = '0;
    {left_column_mid_port, right_column_mid_port, capstan_below_normal} = '0;
    // motion kept requested so the idle timer stays quiet by default
    motion_request_extended = 1'b1;
    tick(2);
    `CHK({rewind_active, high_speed_field, polarity_hold_register}, 6'h0)
    arst_n = 1'b1;
    tick(1);
    foreach (rows[j]) begin
      {send, unload_rewind_btn, load_rewind_btn, unit_ready} = rows[j][4:1];
      tick(3);
      {send, unload_rewind_btn, load_rewind_btn, unit_ready} = '0;
      `CHK(rewind_active, rows[j].a)
      `CHK(tape_bkwd, rows[j].a)
      load_point = 1'b1;
      tick(1);
      `CHK(rewind_done, rows[j].a)
      `CHK({rewind_active, tape_bkwd, tape_fwd}, 3'h0)
      load_point = 1'b0;
      tick(1);
    end
    start_cmd();
    for (int j = 0; j < 4; j++) begin
      {left_column_mid_port, right_column_mid_port} = j[1:0];
      tick(1);
      `CHK({left_reel_ccw, right_reel_ccw}, j[1:0])
    end
    `CHK({polarity_hold_register, capstan_normal_ctl}, 5'h1f)
    win(1, 2);
    tick(4);
    `CHK(high_speed_field, 1'b0)
    win(2, 2);
    `WAITFOR(high_speed_field === 1'b1)
    tick(1);
    `CHK({polarity_hold_register, capstan_normal_ctl, rewind_current, slowdown_current}, 7'h02)
    win(2, 0);
    `WAITFOR(slowdown_current === 1'b1)
    `CHK({rewind_current, high_speed_field}, 2'h1)
    left_radius_sense = 1'b1;
    tick(2);
    `CHK(slowdown, 1'b1)
    capstan_below_normal = 1'b1;
    tick(2);
    `CHK({high_speed_field, polarity_hold_register, capstan_normal_ctl}, 6'h1f)
    `CHK(rewind_active, 1'b1)
    load_point = 1'b1;
    tick(1);
    `CHK({rewind_done, rewind_active, slowdown}, 3'h4)
    {load_point, capstan_below_normal} = '0;
    tick(1);
    // left radius still sensed at start: the reels may run fast, no latch
    start_cmd();
    left_radius_sense = 1'b0;
    win(2, 2);
    tick(4);
    `CHK({high_speed_field, tape_bkwd}, 2'h1)
    press(2);
    tick(1);
    `CHK(rewind_active, 1'b1)
    press(2);
    `CHK({rewind_active, rewind_done}, 2'h0)
    start_cmd();
    win(2, 2);
    `WAITFOR(high_speed_field === 1'b1)
    press(2);
    `CHK({slowdown, rewind_active}, 2'h3)
    #20 arst_n = 1'b0;
    #10 `CHK({rewind_active, high_speed_field, slowdown}, 3'h0)
    tick(2);
    arst_n = 1'b1;
    tick(1);
    start_cmd();
    press(HOLD_N + 5);
    `CHK({rewind_active, rewind_done}, 2'h0)
    motion_request_extended = 1'b0;
    tick(IDLE_N + 5);
    start_cmd();
    `CHK({tape_fwd, tape_bkwd}, 2'h2)
    motion_request_extended = 1'b1;
    for (int j = 0; j < 8; j++) begin
      `CHK(tape_fwd, 1'b1)
      capstan_quarter_tach = 1'b1;
      tick(1);
      capstan_quarter_tach = 1'b0;
      tick(1);
    end
    `CHK({tape_fwd, tape_bkwd}, 2'h1)
    close_out();
  end
endmodule
`default_nettype wire
